// *** hdl/adc_clock_divider.sv ***
// Converter clock enable from system clock, divide by 2**code
`timescale 1ns/1ps
module adc_clock_divider (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic [2:0] code,
    output logic tick
);
    logic [6:0] count_q;
    logic [6:0] limit;
    assign limit = 7'((8'h01 << code) - 8'h01);
    assign tick = (count_q == limit) && !clear;
    always_ff @(posedge clk) begin
        if (reset || clear || tick) begin
            count_q <= 7'h00;
        end else begin
            count_q <= count_q + 7'h01;
        end
    end
endmodule // adc_clock_divider

// *** hdl/adc_ctrl.sv ***
// Converter control, result registers and AXI4-Lite slave
`timescale 1ns/1ps
module adc_ctrl (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [3:0] PIN_ANALOG_SELECT,
    input wire logic [11:0] CONVERTER_DATA,
    output logic CONVERTER_POWER,
    output logic CONVERTER_RESET,
    output logic CONVERTER_SAMPLE,
    output logic CONVERTER_CLOCK_EN,
    output logic [3:0] EXTERNAL_ANALOG_INPUTS,
    output logic [2:0] AMPLIFIER_OUTPUT_TAP,
    output logic DAC_OUTPUT_SELECT,
    output logic [2:0] REFERENCE_ROUTE,
    output logic [3:0] PIN_DIGITAL_DISABLE,
    output logic [3:0] PIN_PULLUP_DISABLE,
    output logic CONVERSION_DONE_IRQ
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } conv_state_t;

    conv_state_t state_q, state_d;
    logic [7:0] conv_control_q;
    logic [7:0] src_select_q;
    logic [11:0] result_q;
    logic [4:0] tick_count_q;
    logic start_prev_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic aw_held_q;
    logic w_held_q;

    // Bit 6 is the busy flag and ignores writes
    wire logic start_bit = conv_control_q[adc_ctrl_pkg::BIT_START];
    wire logic enable_bit = conv_control_q[adc_ctrl_pkg::BIT_ENABLE];
    wire logic align_bit = conv_control_q[adc_ctrl_pkg::BIT_ALIGN];
    wire logic [3:0] channel = conv_control_q[3:0];
    wire logic [2:0] source = src_select_q[7:5];
    wire logic [1:0] reference = src_select_q[4:3];
    wire logic [2:0] clk_code = src_select_q[2:0];
    wire logic busy = (state_q != ST_IDLE);
    wire logic start_seen = start_prev_q && !start_bit && enable_bit;
    wire logic tick;
    wire logic last_tick = tick && (tick_count_q == adc_ctrl_pkg::TOTAL_CYCLES - 5'h01);
    wire logic finish = (state_q == ST_CONVERT) && last_tick;

    // Result byte packing
    wire logic [7:0] result_high = align_bit ? {4'h0, result_q[11:8]}
                                             : result_q[11:4];
    wire logic [7:0] result_low = align_bit ? result_q[7:0]
                                            : {result_q[3:0], 4'h0};
    wire logic [7:0] conv_readback = {start_bit, busy, conv_control_q[5:0]};

    // Input routing
    wire logic ext_source = (source == 3'h0) || (source > adc_ctrl_pkg::SRC_DAC);
    wire logic ext_pin_valid = (channel <= adc_ctrl_pkg::LAST_EXT_CHANNEL);
    wire logic [3:0] ext_route = (ext_source && ext_pin_valid) ? (4'h1 << channel[1:0])
                                                               : 4'h0;
    wire logic [2:0] amp_route = (source >= 3'h1 && source <= 3'h3)
                                 ? 3'(3'h1 << (source - 3'h1)) : 3'h0;
    wire logic [2:0] ref_route = (reference == 2'h1) ? 3'b010
                               : (reference == 2'h2) ? 3'b100
                               : 3'b001;

    // AXI write decode
    wire logic aw_now = aw_held_q || S_AXI_AWVALID;
    wire logic w_now = w_held_q || S_AXI_WVALID;
    wire logic do_write = aw_now && w_now && !S_AXI_BVALID;
    wire logic [3:0] wr_addr = aw_held_q ? aw_addr_q : S_AXI_AWADDR;
    wire logic [31:0] wr_data = w_held_q ? w_data_q : S_AXI_WDATA;
    wire logic [3:0] wr_strb = w_held_q ? w_strb_q : S_AXI_WSTRB;
    wire logic wr_ctrl = do_write && wr_addr == adc_ctrl_pkg::ADDR_CONV_CTRL && wr_strb[0];
    wire logic wr_src = do_write && wr_addr == adc_ctrl_pkg::ADDR_SRC_SEL && wr_strb[0];
    wire logic wr_ok = (wr_addr == adc_ctrl_pkg::ADDR_CONV_CTRL)
                    || (wr_addr == adc_ctrl_pkg::ADDR_SRC_SEL);

    // AXI read decode
    wire logic do_read = S_AXI_ARVALID && !S_AXI_RVALID;
    wire logic rd_ok = (S_AXI_ARADDR[1:0] == 2'h0) && (S_AXI_ARADDR <= adc_ctrl_pkg::ADDR_SRC_SEL);
    wire logic [7:0] rd_byte = (S_AXI_ARADDR == adc_ctrl_pkg::ADDR_RESULT_LOW) ? result_low
                             : (S_AXI_ARADDR == adc_ctrl_pkg::ADDR_RESULT_HIGH) ? result_high
                             : (S_AXI_ARADDR == adc_ctrl_pkg::ADDR_CONV_CTRL) ? conv_readback
                             : (S_AXI_ARADDR == adc_ctrl_pkg::ADDR_SRC_SEL) ? src_select_q
                             : 8'h00;

    adc_clock_divider divider (
        .clk(CLK),
        .reset(RESET),
        .clear(!busy || start_bit || !enable_bit),
        .code(clk_code),
        .tick(tick)
    );

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_seen) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tick && tick_count_q == adc_ctrl_pkg::SAMPLE_CYCLES - 5'h01) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (last_tick) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (start_bit || !enable_bit) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q <= ST_IDLE;
            tick_count_q <= 5'h00;
            start_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            start_prev_q <= start_bit;
            if (state_d == ST_IDLE || start_seen) begin
                tick_count_q <= 5'h00;
            end else if (tick) begin
                tick_count_q <= tick_count_q + 5'h01;
            end
        end
    end

    // Result captured only by a completing, enabled conversion
    always_ff @(posedge CLK) begin
        if (RESET) begin
            result_q <= 12'h000;
        end else if (finish && enable_bit && !start_bit) begin
            result_q <= CONVERTER_DATA;
        end
    end

    // Register file
    always_ff @(posedge CLK) begin
        if (RESET) begin
            conv_control_q <= adc_ctrl_pkg::CONV_CTRL_RESET;
            src_select_q <= adc_ctrl_pkg::SRC_SEL_RESET;
        end else begin
            if (wr_ctrl) begin
                conv_control_q <= {wr_data[7], 1'b0, wr_data[5:0]};
            end
            if (wr_src) begin
                src_select_q <= wr_data[7:0];
            end
        end
    end

    // AXI channel handshakes
    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= adc_ctrl_pkg::RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= adc_ctrl_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_ARREADY <= 1'b0;
            if (do_write) begin
                S_AXI_AWREADY <= !aw_held_q;
                S_AXI_WREADY <= !w_held_q;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
            end else begin
                if (S_AXI_AWVALID && !aw_held_q && !S_AXI_AWREADY) begin
                    aw_held_q <= 1'b1;
                    aw_addr_q <= S_AXI_AWADDR;
                    S_AXI_AWREADY <= 1'b1;
                end
                if (S_AXI_WVALID && !w_held_q && !S_AXI_WREADY) begin
                    w_held_q <= 1'b1;
                    w_data_q <= S_AXI_WDATA;
                    w_strb_q <= S_AXI_WSTRB;
                    S_AXI_WREADY <= 1'b1;
                end
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (do_read && !S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b1;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= {24'h00_0000, rd_byte};
                S_AXI_RRESP <= rd_ok ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Analog side controls, all registered
    always_ff @(posedge CLK) begin
        if (RESET) begin
            CONVERTER_POWER <= 1'b0;
            CONVERTER_RESET <= 1'b1;
            CONVERTER_SAMPLE <= 1'b0;
            CONVERTER_CLOCK_EN <= 1'b0;
            EXTERNAL_ANALOG_INPUTS <= 4'h0;
            AMPLIFIER_OUTPUT_TAP <= 3'h0;
            DAC_OUTPUT_SELECT <= 1'b0;
            REFERENCE_ROUTE <= 3'b001;
            PIN_DIGITAL_DISABLE <= 4'h0;
            PIN_PULLUP_DISABLE <= 4'h0;
            CONVERSION_DONE_IRQ <= 1'b0;
        end else begin
            CONVERTER_POWER <= enable_bit;
            CONVERTER_RESET <= start_bit || !enable_bit;
            CONVERTER_SAMPLE <= (state_d == ST_SAMPLE);
            CONVERTER_CLOCK_EN <= tick && busy;
            EXTERNAL_ANALOG_INPUTS <= ext_route;
            AMPLIFIER_OUTPUT_TAP <= amp_route;
            DAC_OUTPUT_SELECT <= (source == adc_ctrl_pkg::SRC_DAC);
            REFERENCE_ROUTE <= ref_route;
            PIN_DIGITAL_DISABLE <= PIN_ANALOG_SELECT;
            PIN_PULLUP_DISABLE <= PIN_ANALOG_SELECT;
            CONVERSION_DONE_IRQ <= finish && enable_bit && !start_bit;
        end
    end
endmodule // adc_ctrl

// *** hdl/adc_ctrl_pkg.sv ***
// Shared constants for the converter control block
package adc_ctrl_pkg;
    localparam int RESULT_BITS = 12;
    localparam logic [3:0] ADDR_RESULT_LOW = 4'h0;
    localparam logic [3:0] ADDR_RESULT_HIGH = 4'h4;
    localparam logic [3:0] ADDR_CONV_CTRL = 4'h8;
    localparam logic [3:0] ADDR_SRC_SEL = 4'hC;
    localparam logic [3:0] ADDR_PIN_STATUS = 4'h0;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
    localparam logic [7:0] SRC_SEL_RESET = 8'h00;
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_ALIGN = 4;
    localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
    localparam logic [4:0] CONVERT_CYCLES = 5'h0C;
    localparam logic [4:0] TOTAL_CYCLES = 5'h10;
    localparam logic [3:0] LAST_EXT_CHANNEL = 4'h3;
    localparam logic [2:0] SRC_DAC = 3'h4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam time CLK_PERIOD_NS = 25;
endpackage

// *** testbench/adc_ctrl_assertions.sv ***
// Concurrent checks on the converter control block ports
`timescale 1ns/1ps
module adc_ctrl_assertions (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [3:0] PIN_ANALOG_SELECT,
    input wire logic CONVERTER_POWER,
    input wire logic CONVERTER_RESET,
    input wire logic CONVERTER_SAMPLE,
    input wire logic CONVERTER_CLOCK_EN,
    input wire logic [3:0] EXTERNAL_ANALOG_INPUTS,
    input wire logic [2:0] AMPLIFIER_OUTPUT_TAP,
    input wire logic DAC_OUTPUT_SELECT,
    input wire logic [2:0] REFERENCE_ROUTE,
    input wire logic [3:0] PIN_DIGITAL_DISABLE,
    input wire logic [3:0] PIN_PULLUP_DISABLE,
    input wire logic CONVERSION_DONE_IRQ
);
    logic [4:0] ticks_q;
    logic [4:0] ticks_d;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Converter ticks since the core was last held in reset
    assign ticks_d = CONVERTER_RESET ? 5'h00 : ticks_q + {4'h0, CONVERTER_CLOCK_EN};
    always_ff @(posedge CLK) begin
        ticks_q <= RESET ? 5'h00 : ticks_d;
    end
    a_irq_after_sixteen: assert property (CONVERSION_DONE_IRQ |-> ticks_d == 5'h10)
        else $error("done pulse not after sixteen ticks");
    a_sample_four_ticks: assert property (CONVERTER_SAMPLE |-> ticks_q < 5'h04)
        else $error("sampling ran past four ticks");
    a_sample_end_count: assert property ($fell(CONVERTER_SAMPLE) && !CONVERTER_RESET
        |-> ticks_d == 5'h04)
        else $error("sampling ended early");
    a_irq_single_pulse: assert property (CONVERSION_DONE_IRQ |=> !CONVERSION_DONE_IRQ)
        else $error("done pulse too long");
    a_reset_idles_core: assert property (CONVERTER_RESET |-> !CONVERTER_SAMPLE
        && !CONVERTER_CLOCK_EN)
        else $error("core active while held");
    a_power_off_held: assert property (!CONVERTER_POWER |-> CONVERTER_RESET)
        else $error("core unpowered but not held");
    a_input_exclusive: assert property ($onehot0({EXTERNAL_ANALOG_INPUTS,
        AMPLIFIER_OUTPUT_TAP, DAC_OUTPUT_SELECT}))
        else $error("two analog inputs joined");
    a_reference_single: assert property ($onehot(REFERENCE_ROUTE))
        else $error("reference route not one-hot");
    a_pin_function_off: assert property (!$past(RESET) |-> PIN_DIGITAL_DISABLE ==
        $past(PIN_ANALOG_SELECT) && PIN_PULLUP_DISABLE == $past(PIN_ANALOG_SELECT))
        else $error("analog pin keeps digital function");
    cover property (CONVERSION_DONE_IRQ);
    cover property ($rose(CONVERTER_SAMPLE));
    cover property (DAC_OUTPUT_SELECT);
endmodule // adc_ctrl_assertions
bind adc_ctrl adc_ctrl_assertions checker_i (.CLK, .RESET, .PIN_ANALOG_SELECT,
    .CONVERTER_POWER, .CONVERTER_RESET, .CONVERTER_SAMPLE, .CONVERTER_CLOCK_EN,
    .EXTERNAL_ANALOG_INPUTS, .AMPLIFIER_OUTPUT_TAP, .DAC_OUTPUT_SELECT, .REFERENCE_ROUTE,
    .PIN_DIGITAL_DISABLE, .PIN_PULLUP_DISABLE, .CONVERSION_DONE_IRQ);

// *** testbench/adc_ctrl_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_ctrl_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, pin_sel = 4'h0, ext, dig_off, pull_off, ch;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic [11:0] level = 12'h000, conv_data, v;
    logic awready, wready, bvalid, arready, rvalid, pwr, creset, sample, clk_en, dac, irq;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] amp, route, s;
    logic [15:0] held;
    int mismatches = 0, compares = 0, cyc = 0, t0 = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            mismatches++;
            report_and_stop();
        end
    end
    adc_ctrl dut (.CLK(clk), .RESET(reset), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .PIN_ANALOG_SELECT(pin_sel), .CONVERTER_DATA(conv_data), .CONVERTER_POWER(pwr),
        .CONVERTER_RESET(creset), .CONVERTER_SAMPLE(sample), .CONVERTER_CLOCK_EN(clk_en),
        .EXTERNAL_ANALOG_INPUTS(ext), .AMPLIFIER_OUTPUT_TAP(amp), .DAC_OUTPUT_SELECT(dac),
        .REFERENCE_ROUTE(route), .PIN_DIGITAL_DISABLE(dig_off), .PIN_PULLUP_DISABLE(pull_off),
        .CONVERSION_DONE_IRQ(irq));
    analog_core_model core (.clk(clk), .power(pwr), .hold_reset(creset), .level(level),
        .data(conv_data));
    function automatic logic [15:0] packed_result(input logic [11:0] val, input logic al);
        return al ? {4'h0, val} : {val, 4'h0};
    endfunction
    function automatic logic [7:0] src_exp(input logic [2:0] sv, input logic [3:0] cv);
        return {(((sv == 3'h0 || sv > 3'h4) && cv < 4'h4) ? 4'h1 << cv : 4'h0),
            ((sv != 3'h0 && sv < 3'h4) ? 3'h1 << (sv - 3'h1) : 3'h0), sv == 3'h4};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic convert(input logic [11:0] val, input logic al);
        level <= val;
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, {3'b101, al, 4'h0});
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, {3'b001, al, 4'h0});
        t0 = cyc;
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        rd = $urandom(34);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd_reg(adc_ctrl_pkg::ADDR_SRC_SEL);
        check(rd, 32'h0000_0000);
        rd_reg(4'h2);
        check(rs, adc_ctrl_pkg::RESP_SLVERR);
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, 8'h40);
        check(rs, adc_ctrl_pkg::RESP_OKAY);
        rd_reg(adc_ctrl_pkg::ADDR_CONV_CTRL);
        check(rd, 32'h0000_0000);
        $display("register test done");
        for (int c = 0; c < 8; c++) begin
            wr(adc_ctrl_pkg::ADDR_SRC_SEL, {5'h00, c[2:0]});
            v = 12'($urandom);
            convert(v, c[0]);
            rd_reg(adc_ctrl_pkg::ADDR_CONV_CTRL);
            check(rd[6], 1'b1);
            while (irq !== 1'b1) @(posedge clk);
            check((cyc - t0 >= (16 << c)) && (cyc - t0 <= (16 << c) + 3), 1'b1);
            held = packed_result(v, c[0]);
            rd_reg(adc_ctrl_pkg::ADDR_CONV_CTRL);
            check(rd[6], 1'b0);
            rd_reg(adc_ctrl_pkg::ADDR_RESULT_HIGH);
            check(rd, {24'h00_0000, held[15:8]});
            rd_reg(adc_ctrl_pkg::ADDR_RESULT_LOW);
            check(rd, {24'h00_0000, held[7:0]});
        end
        $display("conversion test done");
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, 8'h90);
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, 8'h10);
        rd_reg(adc_ctrl_pkg::ADDR_CONV_CTRL);
        check(rd, 32'h0000_0010);
        check(pwr, 1'b0);
        convert(12'hABC, 1'b1);
        wr(adc_ctrl_pkg::ADDR_CONV_CTRL, 8'h10);
        // Outlast a full conversion at the slowest divider
        repeat (2100) @(posedge clk);
        rd_reg(adc_ctrl_pkg::ADDR_RESULT_LOW);
        check(rd, {24'h00_0000, held[7:0]});
        $display("disable test done");
        for (int i = 0; i < 16; i++) begin
            s = i[2:0];
            ch = (s != 3'h0 && s < 3'h5) ? 4'(4 + $urandom % 12) : 4'($urandom);
            wr(adc_ctrl_pkg::ADDR_CONV_CTRL, {4'h0, ch});
            wr(adc_ctrl_pkg::ADDR_SRC_SEL, {s, i[3:2], 3'h0});
            pin_sel <= 4'($urandom);
            repeat (3) @(posedge clk);
            check({ext, amp, dac}, src_exp(s, ch));
            check(route, i[3:2] == 2'h1 ? 3'h2 : i[3:2] == 2'h2 ? 3'h4 : 3'h1);
            check({dig_off, pull_off}, {pin_sel, pin_sel});
        end
        $display("routing test done");
        report_and_stop();
    end
endmodule // adc_ctrl_tb

// *** testbench/analog_core_model.sv ***
// Behavioural analog core that hands results to the control block
`timescale 1ns/1ps
module analog_core_model (
    input wire logic clk,
    input wire logic power,
    input wire logic hold_reset,
    input wire logic [11:0] level,
    output logic [11:0] data
);
    initial data = 12'h5A5;
    always @(posedge clk) begin
        if (power && !hold_reset) begin
            data <= level;
        end else begin
            data <= ~data; // Meaningless while off or held
        end
    end
endmodule // analog_core_model
